/* File: hw/jpd_pkg.sv */
// ==========================================================
// Programming data path constants and carriers
package jpd_pkg;

  // ========================================================
  // Instruction codes, 4-bit instruction register
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] IR_CORE_HOLD = 4'hc;
  localparam logic [IR_W-1:0] IR_UNLOCK_KEY = 4'h4;
  localparam logic [IR_W-1:0] IR_CMD_ENTRY = 4'h5;
  localparam logic [IR_W-1:0] IR_PAGE_FILL = 4'h6;
  localparam logic [IR_W-1:0] IR_PAGE_DUMP = 4'h7;

  // ========================================================
  // Register widths and field positions
  localparam int KEY_W = 16;
  localparam int CMD_W = 15;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 24;
  localparam int OP_LSB = 8;
  localparam int LATCH_BIT = 14;
  localparam int STATUS_BIT = 9;
  localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'ha370;

  // ========================================================
  // Upper seven command bits
  localparam logic [6:0] OP_MODE_ENTER = 7'h23;
  localparam logic [6:0] OP_LD_EXT = 7'h0b;
  localparam logic [6:0] OP_LD_ADDR_HI = 7'h07;
  localparam logic [6:0] OP_LD_ADDR_LO = 7'h03;
  localparam logic [6:0] OP_LD_DATA_LO = 7'h13;
  localparam logic [6:0] OP_LD_DATA_HI = 7'h17;
  localparam logic [6:0] OP_RD_LO = 7'h32;
  localparam logic [6:0] OP_RD_HI = 7'h36;

  // ========================================================
  // Timing
  localparam logic [3:0] PB_WR_DELAY = 4'h2;
  localparam int MCLK_PERIOD_NS = 40;
  localparam int HOLD_TIMEOUT_NS = 40960;
  localparam int HOLD_TIMEOUT_CYC =
    (HOLD_TIMEOUT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int HOLD_CNT_W = 16;

  // ========================================================
  // Carriers and state
  typedef struct packed {
    logic [CMD_W-1:0] cmd;
    logic strobe;
    logic latch;
    logic [ADDR_W-1:0] addr;
    logic [15:0] dword;
    logic pb_wr;
    logic pb_hi;
    logic [BYTE_W-1:0] pb_byte;
  } jpd_mem_req_t;

  typedef struct packed {
    logic hold;
    logic [KEY_W-1:0] key;
    logic unlocked;
    logic [CMD_W-1:0] sr;
    logic [CMD_W-1:0] cmd;
    logic [ADDR_W-1:0] pc;
    logic [15:0] dword;
    logic [BYTE_W-1:0] rbyte;
    logic idle_d;
    logic [IR_W-1:0] ir_d;
    logic fill_hi;
    logic fill_started;
    logic dump_hi;
    logic [BYTE_W-1:0] tmp;
    logic [3:0] wr_cnt;
    logic strobe;
    logic latch;
    logic pb_wr;
    logic pb_hi;
    logic [BYTE_W-1:0] pb_byte;
    logic tdo;
  } jpd_tck_st_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [HOLD_CNT_W-1:0] cnt;
  } jpd_mclk_st_t;

endpackage

/* File: hw/jpd_top.sv */
`timescale 1ns/100ps
module jpd_top
  import jpd_pkg::*;
#(
  parameter logic [HOLD_CNT_W-1:0] HOLD_CYC =
    HOLD_CNT_W'(HOLD_TIMEOUT_CYC)
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tdi,
  input wire logic [IR_W-1:0] ir,
  input wire logic tap_capture,
  input wire logic tap_shift,
  input wire logic tap_update,
  input wire logic tap_idle,
  input wire logic [15:0] rd_word,
  input wire logic mem_ready,
  output logic tdo,
  output logic core_hold,
  output jpd_mem_req_t mem
);

  // ========================================================
  // Link side, clocked by tck
  jpd_tck_st_t s;
  jpd_tck_st_t next_s;
  logic new_ir;
  logic idle_rise;

  // Address counter step, shared by fill and dump
  function automatic logic [ADDR_W-1:0] inc_addr(
    input logic [ADDR_W-1:0] a
  );
    inc_addr = a + ADDR_W'(1);
  endfunction

  assign new_ir = ir != s.ir_d;
  assign idle_rise = tap_idle && !s.idle_d;

  // Next state of the link side
  always_comb begin
    next_s = s;
    next_s.strobe = 1'b0;
    next_s.latch = 1'b0;
    next_s.pb_wr = 1'b0;
    next_s.ir_d = ir;
    next_s.idle_d = tap_idle;
    // Byte phases restart whenever a new instruction is loaded
    if (new_ir) begin
      next_s.fill_hi = 1'b0;
      next_s.fill_started = 1'b0;
      next_s.dump_hi = 1'b0;
    end
    unique case (ir)
      IR_CORE_HOLD: begin
        // Only the data path is touched; the TAP is left alone
        if (tap_shift) begin
          next_s.hold = tdi;
        end
      end
      IR_UNLOCK_KEY: begin
        if (tap_shift) begin
          next_s.key = {tdi, s.key[KEY_W-1:1]};
        end
        if (tap_update) begin
          next_s.unlocked = s.key == UNLOCK_KEY;
        end
      end
      IR_CMD_ENTRY: begin
        if (tap_capture) begin
          // Status of the last command plus its read byte
          next_s.sr = {5'h00, mem_ready, 1'b0, s.rbyte};
        end else if (tap_shift) begin
          next_s.sr = {tdi, s.sr[CMD_W-1:1]};
        end
        if (tap_update && s.unlocked) begin
          next_s.cmd = s.sr;
        end
      end
      IR_PAGE_FILL: begin
        if (tap_shift) begin
          next_s.sr[BYTE_W-1:0] = {tdi, s.sr[BYTE_W-1:1]};
        end
        if (tap_update && s.unlocked) begin
          next_s.tmp = s.sr[BYTE_W-1:0];
          next_s.wr_cnt = PB_WR_DELAY;
          next_s.pb_hi = s.fill_hi;
          next_s.fill_hi = !s.fill_hi;
          next_s.fill_started = 1'b1;
          if (!s.fill_hi && s.fill_started) begin
            next_s.pc = inc_addr(s.pc);
          end
        end
      end
      IR_PAGE_DUMP: begin
        if (tap_capture && s.unlocked) begin
          next_s.sr[BYTE_W-1:0] = s.dump_hi ? rd_word[15:8] :
                                  rd_word[7:0];
          next_s.dump_hi = !s.dump_hi;
          if (s.dump_hi) begin
            next_s.pc = inc_addr(s.pc);
          end
        end else if (tap_shift) begin
          next_s.sr[BYTE_W-1:0] = {tdi, s.sr[BYTE_W-1:1]};
        end
      end
      default: begin
        next_s.sr = s.sr;
      end
    endcase
    // Page buffer write lands a fixed count after the update
    if (s.wr_cnt != 4'h0) begin
      next_s.wr_cnt = s.wr_cnt - 4'h1;
      if (s.wr_cnt == 4'h1) begin
        next_s.pb_wr = 1'b1;
        next_s.pb_byte = s.tmp;
      end
    end
    // One strobe per idle entry; locked part executes nothing
    if (ir == IR_CMD_ENTRY && idle_rise && s.unlocked) begin
      next_s.strobe = 1'b1;
      next_s.latch = s.cmd[LATCH_BIT];
      // Mode entry, erase and write commands go out unchanged
      unique case (s.cmd[CMD_W-1:OP_LSB])
        OP_LD_EXT: next_s.pc[23:16] = s.cmd[7:0];
        OP_LD_ADDR_HI: next_s.pc[15:8] = s.cmd[7:0];
        OP_LD_ADDR_LO: next_s.pc[7:0] = s.cmd[7:0];
        OP_LD_DATA_LO: next_s.dword[7:0] = s.cmd[7:0];
        OP_LD_DATA_HI: next_s.dword[15:8] = s.cmd[7:0];
        OP_RD_LO: next_s.rbyte = rd_word[7:0];
        OP_RD_HI: next_s.rbyte = rd_word[15:8];
        default: next_s.rbyte = s.rbyte;
      endcase
    end
    // Serial output follows the selected register's LSB
    unique case (ir)
      IR_CORE_HOLD: next_s.tdo = next_s.hold;
      IR_UNLOCK_KEY: next_s.tdo = next_s.key[0];
      IR_CMD_ENTRY, IR_PAGE_FILL, IR_PAGE_DUMP:
        next_s.tdo = next_s.sr[0];
      default: next_s.tdo = 1'b0;
    endcase
  end

  // Link side registers; power-on clears the unlock state
  always_ff @(posedge tck or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ========================================================
  // Core side, clocked by mclk
  jpd_mclk_st_t c;
  jpd_mclk_st_t next_c;

  // Time-out restarts while the synchronised hold is high
  always_comb begin
    next_c = c;
    next_c.sync1 = s.hold;
    next_c.sync2 = c.sync1;
    if (c.sync2) begin
      next_c.cnt = HOLD_CYC;
    end else if (c.cnt != '0) begin
      next_c.cnt = c.cnt - HOLD_CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  // ========================================================
  // Outputs
  // The raw hold bit is ORed in so the hold bites at once, not
  // after the synchroniser; release is still mclk-timed
  assign core_hold = s.hold || c.sync2 || (c.cnt != '0);
  assign tdo = s.tdo;
  assign mem.cmd = s.cmd;
  assign mem.strobe = s.strobe;
  assign mem.latch = s.latch;
  assign mem.addr = s.pc;
  assign mem.dword = s.dword;
  assign mem.pb_wr = s.pb_wr;
  assign mem.pb_hi = s.pb_hi;
  assign mem.pb_byte = s.pb_byte;

  // ========================================================
  // Checks
  sequence fill_update_s;
    tap_update && ir == IR_PAGE_FILL && s.unlocked;
  endsequence

  sequence cmd_idle_s;
    ir == IR_CMD_ENTRY && idle_rise && s.unlocked;
  endsequence

  unlock_compare_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_update && ir == IR_UNLOCK_KEY |=>
      s.unlocked == ($past(s.key) == UNLOCK_KEY))
    else $error("unlock compare wrong");

  locked_ignore_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    !s.unlocked |=> $stable(mem.cmd) && !mem.strobe)
    else $error("locked part took a command");

  strobe_once_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    cmd_idle_s |=> mem.strobe ##1 !mem.strobe)
    else $error("idle strobe not single");

  fill_write_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    fill_update_s |-> ##[1:11] mem.pb_wr)
    else $error("page buffer write late");

  fill_alt_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    fill_update_s and !new_ir |=> s.fill_hi != $past(s.fill_hi))
    else $error("fill byte did not alternate");

  fill_pc_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    fill_update_s and !new_ir && s.fill_started && !s.fill_hi
      |=> s.pc == $past(s.pc) + 24'h1)
    else $error("fill pre-increment wrong");

  dump_pc_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_capture && ir == IR_PAGE_DUMP && s.unlocked && !new_ir
      && s.dump_hi |=> s.pc == $past(s.pc) + 24'h1)
    else $error("dump post-increment wrong");

  cmd_status_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_capture && ir == IR_CMD_ENTRY |=>
      s.sr[STATUS_BIT] == $past(mem_ready))
    else $error("status bit not captured");

  hold_shift_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_shift && ir == IR_CORE_HOLD |=>
      s.hold == $past(tdi) && (core_hold || !s.hold))
    else $error("hold bit not shifted");

  hold_stretch_a: assert property (
    @(posedge mclk) disable iff (!rst_b)
    $fell(c.sync2) |-> core_hold [*8])
    else $error("hold released without time-out");

  // Serial path and command execution
  key_shift_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_shift && ir == IR_UNLOCK_KEY |=>
      s.key == {$past(tdi), $past(s.key[KEY_W-1:1])})
    else $error("key shift wrong");

  cmd_apply_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_update && ir == IR_CMD_ENTRY && s.unlocked |=>
      mem.cmd == $past(s.sr))
    else $error("command not applied");

  tdo_lsb_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_shift && ir == IR_CMD_ENTRY |=> tdo == $past(s.sr[1]))
    else $error("serial out not next bit");

  fill_first_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    fill_update_s and !s.fill_started |=>
      !mem.pb_hi && $stable(mem.addr))
    else $error("first fill not low at preset");

  // Depth three follows the two-cycle page write delay
  fill_byte_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    mem.pb_wr |-> mem.pb_byte == $past(s.sr[BYTE_W-1:0], 3))
    else $error("page buffer byte wrong");

  dump_lo_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    tap_capture && ir == IR_PAGE_DUMP && s.unlocked && !s.dump_hi
      |=> s.sr[BYTE_W-1:0] == $past(rd_word[7:0]))
    else $error("dump low byte wrong");

  addr_load_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    cmd_idle_s and s.cmd[CMD_W-1:OP_LSB] == OP_LD_ADDR_LO |=>
      mem.addr[7:0] == $past(s.cmd[7:0]))
    else $error("low address not loaded");

  data_load_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    cmd_idle_s and s.cmd[CMD_W-1:OP_LSB] == OP_LD_DATA_HI |=>
      mem.dword[15:8] == $past(s.cmd[7:0]))
    else $error("high data not loaded");

  read_byte_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    cmd_idle_s and s.cmd[CMD_W-1:OP_LSB] == OP_RD_HI |=>
      s.rbyte == $past(rd_word[15:8]))
    else $error("read high byte wrong");

  latch_pulse_a: assert property (
    @(posedge tck) disable iff (!rst_b)
    mem.latch |-> mem.strobe && mem.cmd[LATCH_BIT])
    else $error("latch pulse without strobe");

endmodule

/* File: verification/jpd_prog_model.sv */
`timescale 1ns/100ps
// ========================================================
// Programmer model: walks the TAP states, moves 2 ns after tck rise
module jpd_prog_model
  import jpd_pkg::*;
(
  input wire logic tck,
  input wire logic tdo,
  output logic tdi,
  output logic [IR_W-1:0] ir,
  output logic tap_capture,
  output logic tap_shift,
  output logic tap_update,
  output logic tap_idle
);
  // Quiet TAP at time zero
  initial begin
    {tdi, ir, tap_capture, tap_shift, tap_update, tap_idle} = '0;
  end

  task automatic step();
    @(posedge tck);
    #2;
  endtask

  // Ir held two edges so the phase reset lands before capture
  task automatic sel(input logic [IR_W-1:0] c);
    ir = c;
    step();
    step();
  endtask

  // Capture, n shifts, update; cap holds the bits seen on tdo
  task automatic scan(input int n, input logic [15:0] v,
                      output logic [15:0] cap);
    cap = 16'h0000;
    tap_capture = 1'b1;
    step();
    tap_capture = 1'b0;
    tap_shift = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi = v[i];
      cap[i] = tdo;
      step();
    end
    tap_shift = 1'b0;
    tdi = ~tdi; // Released line must not keep the last bit
    tap_update = 1'b1;
    step();
    tap_update = 1'b0;
  endtask

  // One pass through idle, one internal cycle expected
  task automatic run();
    tap_idle = 1'b1;
    step();
    step();
    tap_idle = 1'b0;
    step();
  endtask
endmodule

/* File: verification/jpd_top_tb_top.sv */
`timescale 1ns/100ps
// ========================================================
// Bench for the programming data path
module jpd_top_tb_top;
  import jpd_pkg::*;
  localparam logic [15:0] HOLD = 16'h0010;
  logic mclk = 1'b0;
  logic tck = 1'b0;
  logic rst_b, tdi, tap_capture, tap_shift, tap_update, tap_idle;
  logic mem_ready, tdo, core_hold;
  logic [IR_W-1:0] ir;
  logic [15:0] rd_word, e, cap;
  logic [14:0] v;
  logic [23:0] a0;
  logic [7:0] ob [5];
  jpd_mem_req_t mem;
  logic [31:0] seed = 32'd9353;
  int err_count, compares, cyc, nstb, nlat, n0, l0, k;
  // Page write follows the latch with its first command left out
  logic [14:0] tbl [18] = '{15'h2380, 15'h2310, 15'h2302, 15'h2311,
    15'h0b80, 15'h0780, 15'h0380, 15'h1380, 15'h1780, 15'h3700,
    15'h7700, 15'h3700, 15'h3500, 15'h3700, 15'h3700, 15'h3180,
    15'h3380, 15'h3380};

  // Clocks: link clock unrelated in phase
  always #20 mclk = ~mclk;
  initial begin
    #13;
    forever #40 tck = ~tck;
  end

  jpd_top #(.HOLD_CYC(HOLD)) i_dut (.mclk(mclk), .rst_b(rst_b),
    .tck(tck), .tdi(tdi), .ir(ir), .tap_capture(tap_capture),
    .tap_shift(tap_shift), .tap_update(tap_update),
    .tap_idle(tap_idle), .rd_word(rd_word), .mem_ready(mem_ready),
    .tdo(tdo), .core_hold(core_hold), .mem(mem));
  jpd_prog_model m (.tck(tck), .tdo(tdo), .tdi(tdi), .ir(ir),
    .tap_capture(tap_capture), .tap_shift(tap_shift),
    .tap_update(tap_update), .tap_idle(tap_idle));

  // Flash model: word content derived from its address
  function automatic logic [15:0] memw(input logic [23:0] a);
    return a[15:0] ^ 16'h5a3c;
  endfunction
  assign rd_word = memw(mem.addr);

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string n, input logic [23:0] x,
                     input logic [23:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic cmd(input logic [14:0] c);
    m.scan(15, {1'b0, c}, cap);
    m.run();
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Pulse counters and hang guard
  always @(posedge tck) begin
    nstb += int'(mem.strobe);
    nlat += int'(mem.latch);
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      give_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    mem_ready = 1'b1;
    repeat (2) @(posedge mclk);
    #2 rst_b = 1'b1;
    chk("core_hold", 0, core_hold);
    m.sel(IR_CORE_HOLD);
    m.scan(1, 16'h0001, cap);
    chk("hold_set", 1, core_hold);
    m.sel(IR_UNLOCK_KEY);
    m.scan(16, UNLOCK_KEY ^ 16'h0001, cap);
    m.sel(IR_CMD_ENTRY);
    n0 = nstb;
    cmd(15'h2302);
    chk("locked_strobe", 0, nstb - n0);
    m.sel(IR_UNLOCK_KEY);
    m.scan(16, UNLOCK_KEY, cap);
    m.sel(IR_CMD_ENTRY);
    // Mode entries, loads with random operands, latch and erase
    for (int i = 0; i < 18; i++) begin
      seed = xs(seed);
      v = (i > 3 && i < 9) ? {tbl[i][14:8], seed[7:0]} : tbl[i];
      if (i > 3 && i < 9) ob[i-4] = seed[7:0];
      n0 = nstb;
      l0 = nlat;
      cmd(v);
      chk("strobe", 1, nstb - n0);
      chk("latch", v[14], nlat - l0);
      chk("cmd", v, mem.cmd);
    end
    chk("addr", {ob[0], ob[1], ob[2]}, mem.addr);
    chk("dword", {ob[4], ob[3]}, mem.dword);
    cmd(15'h3200);
    cmd(15'h3600);
    e = memw({ob[0], ob[1], ob[2]});
    chk("rd_lo", e[7:0], cap[7:0]);
    mem_ready = 1'b0;
    cmd(15'h3700);
    chk("rd_hi", e[15:8], cap[7:0]);
    chk("busy", 0, cap[9]);
    mem_ready = 1'b1;
    cmd(15'h3700);
    chk("ready", 1, cap[9]);
    a0 = {ob[0], ob[1], ob[2]};
    m.sel(IR_PAGE_FILL);
    for (int j = 0; j < 4; j++) begin
      seed = xs(seed);
      m.scan(8, seed[15:0], cap);
      k = 0;
      while (mem.pb_wr !== 1'b1 && k < 11) begin
        @(posedge tck);
        #2 k++;
      end
      chk("pb_wr", 1, mem.pb_wr);
      chk("pb_hi", j % 2, mem.pb_hi);
      chk("pb_byte", seed[7:0], mem.pb_byte);
      chk("fill_addr", a0 + 24'(j / 2), mem.addr);
    end
    m.sel(IR_PAGE_DUMP);
    a0 = a0 + 24'h1;
    for (int j = 0; j < 4; j++) begin
      m.scan(8, 16'h0000, cap);
      e = memw(a0 + 24'(j / 2));
      chk("dump", (j % 2) ? e[15:8] : e[7:0], cap[7:0]);
    end
    chk("dump_addr", a0 + 24'd2, mem.addr);
    m.sel(IR_UNLOCK_KEY);
    m.scan(16, 16'h0000, cap);
    m.sel(IR_CMD_ENTRY);
    n0 = nstb;
    cmd(15'h3700);
    chk("cleared_strobe", 0, nstb - n0);
    m.sel(IR_CORE_HOLD);
    m.scan(1, 16'h0000, cap);
    repeat (HOLD - 16'h0004) @(posedge mclk);
    chk("hold_stretch", 1, core_hold);
    repeat (12) @(posedge mclk);
    #2 chk("hold_free", 0, core_hold);
    give_verdict();
  end
endmodule
